// file: mirs_top.sv
// Purpose: interrupt controller with MCU control and status register
// Assumes: AXI4-Lite register access, CPU gives instruction boundaries
// Notes: aresetn acts as the power-on reset of this block
// Notes on behaviour
// - pull-up bit one turns on the pull-ups of Port B pins free of special functions, zero turns them all off
// - a Port B pin used by a special function never gets its pull-up
// - sleep instruction sleeps only while sleep enable is set
// - sleep mode select zero means idle, one means power-down
// - watchdog flag set by watchdog reset, cleared by power-on or zero write
// - pin reset flag set by pin reset, cleared by power-on or zero write
// - power-on flag set by power-on, cleared only by writing zero
// - bits six and two of control status always read zero
// - serve a source only when own enable and global enable are set; the comparator request has no own enable here, only global
// - vectors one to five in fixed order, lower address wins
// - taking an interrupt clears global enable; software may set it again
// - vectoring clears the causing flag; writing one clears some flags
// - flags raised while disabled stay pending until enabled or cleared
// - level interrupt has no flag, pending only while pin is low
// - status register is never saved or restored by hardware
// - response takes four cycles pushing the pc, then the vector runs
// - a multi-cycle instruction finishes before an interrupt is taken
// - response is four cycles longer when taken from sleep
// - return takes four cycles, sets global enable, one instruction follows
// - external interrupt fires from its pin even when driven as output
// - enabled level interrupt requests while its pin is held low
// - low-level request from any Port B pin not used by special functions
// - sense bits pick low level, any change, falling or rising edge
// - pins are sampled first; edges longer than one clock are caught
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module mirs_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic ext_external_interrupt_zero_pin,
   input wire logic ext_external_interrupt_one_pin,
   input wire logic [7:0] portb_pins,
   input wire logic [7:0] portb_special,
   input wire logic timer_zero_overflow,
   input wire logic comparator_interrupt,
   input wire logic wdt_reset_event,
   input wire logic pin_reset_event,
   input wire logic cpu_boundary,
   input wire logic cpu_asleep,
   input wire logic cpu_return_from_interrupt,
   input wire logic cpu_sleep_instr,
   output logic [7:0] portb_pullup_en,
   output logic sleep_enter,
   output logic sleep_mode_select,
   output logic irq_push_pc,
   output logic irq_pop_pc,
   output logic irq_vector_valid,
   output logic [9:0] irq_vector,
   output logic irq_wake
);
   import mirs_pkg::*;

   logic aw_held_ff;
   logic w_held_ff;
   logic [7:0] awaddr_ff;
   logic [7:0] wdata_ff;
   logic wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic do_write;
   logic wr_ic;
   logic wr_cs;
   logic wr_if;
   logic wr_st;
   logic wr_hit;
   logic [7:0] ic_ff;
   logic pullup_bit_ff;
   logic sleep_en_ff;
   logic sleep_mode_ff;
   logic wdt_flag_ff;
   logic pin_flag_ff;
   logic por_flag_ff;
   logic tov_ff;
   logic gie_ff;
   logic [7:0] pullup_ff;
   logic [7:0] cs_read;
   logic [7:0] if_read;
   logic [7:0] rd_val;
   logic rd_hit;
   logic external_interrupt_zero_flag;
   logic external_interrupt_one_flag;
   logic external_interrupt_zero_req;
   logic external_interrupt_one_req;
   logic external_interrupt_zero_clr;
   logic external_interrupt_one_clr;
   logic low_level;
   logic [NUM_SRC-1:0] req;
   logic req_any;
   logic [2:0] req_src;
   mirs_seq_t state_ff;
   mirs_seq_t nxt_state;
   logic [3:0] cnt_ff;
   logic [2:0] src_ff;
   logic [9:0] vector_ff;
   logic accept;
   logic vector_fire;
   logic return_from_interrupt_done;

   // write channel: address and data taken in either order
   assign awready = ~aw_held_ff & ~bvalid_ff;
   assign wready = ~w_held_ff & ~bvalid_ff;
   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign wr_hit = (awaddr_ff == ADDR_INT_CONTROL)
      | (awaddr_ff == ADDR_CTRL_STATUS) | (awaddr_ff == ADDR_INT_FLAG)
      | (awaddr_ff == ADDR_STATUS);
   assign wr_ic = do_write & wstrb_ff & (awaddr_ff == ADDR_INT_CONTROL);
   assign wr_cs = do_write & wstrb_ff & (awaddr_ff == ADDR_CTRL_STATUS);
   assign wr_if = do_write & wstrb_ff & (awaddr_ff == ADDR_INT_FLAG);
   assign wr_st = do_write & wstrb_ff & (awaddr_ff == ADDR_STATUS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_ff <= 1'b0;
         awaddr_ff <= 8'h00;
      end
      else if (awvalid && awready)
      begin
         aw_held_ff <= 1'b1;
         awaddr_ff <= {awaddr[7:2], 2'b00};
      end
      else if (do_write)
         aw_held_ff <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wstrb_ff <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_held_ff <= 1'b1;
         wdata_ff <= wdata[7:0];
         wstrb_ff <= wstrb[0];
      end
      else if (do_write)
         w_held_ff <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_ff <= 1'b0;
   end

   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   // read channel: one read at a time, no read side effects
   assign cs_read = {pullup_bit_ff, 1'b0, sleep_en_ff, sleep_mode_ff,
      wdt_flag_ff, 1'b0, pin_flag_ff, por_flag_ff};
   assign if_read = {external_interrupt_one_flag, external_interrupt_zero_flag, 1'b0, tov_ff, 4'h0};

   always_comb
   begin
      rd_hit = 1'b1;
      unique case (araddr[7:2])
         ADDR_INT_CONTROL[7:2]: rd_val = ic_ff;
         ADDR_CTRL_STATUS[7:2]: rd_val = cs_read;
         ADDR_INT_FLAG[7:2]: rd_val = if_read;
         ADDR_STATUS[7:2]: rd_val = {gie_ff, 7'h00};
         default:
         begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   assign arready = ~rvalid_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= {24'h00_0000, rd_val};
         rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid_ff <= 1'b0;
   end

   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   // control bits of the control status register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pullup_bit_ff <= 1'b0;
         sleep_en_ff <= 1'b0;
         sleep_mode_ff <= 1'b0;
      end
      else if (wr_cs)
      begin
         pullup_bit_ff <= wdata_ff[CS_PULLUP];
         sleep_en_ff <= wdata_ff[CS_SLEEP_EN];
         sleep_mode_ff <= wdata_ff[CS_SLEEP_MODE];
      end
   end

   // reset cause flags: set wins over a zero write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdt_flag_ff <= 1'b0;
         pin_flag_ff <= 1'b0;
         por_flag_ff <= 1'b1;
      end
      else
      begin
         if (wdt_reset_event)
            wdt_flag_ff <= 1'b1;
         else if (wr_cs && !wdata_ff[CS_WDT_FLAG])
            wdt_flag_ff <= 1'b0;
         if (pin_reset_event)
            pin_flag_ff <= 1'b1;
         else if (wr_cs && !wdata_ff[CS_PIN_FLAG])
            pin_flag_ff <= 1'b0;
         if (wr_cs && !wdata_ff[CS_POR_FLAG])
            por_flag_ff <= 1'b0;
      end
   end

   // pull-ups off on pins taken by special functions
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pullup_ff <= 8'h00;
      else
         pullup_ff <= {8{pullup_bit_ff}} & ~portb_special;
   end

   assign portb_pullup_en = pullup_ff;
   assign sleep_enter = cpu_sleep_instr & sleep_en_ff;
   assign sleep_mode_select = sleep_mode_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ic_ff <= IC_RESET;
      else if (wr_ic)
         ic_ff <= wdata_ff;
   end

   // timer overflow flag: hardware set wins over any clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tov_ff <= 1'b0;
      else if (timer_zero_overflow)
         tov_ff <= 1'b1;
      else if ((wr_if && wdata_ff[IF_TOV])
         || (vector_fire && src_ff == SRC_TOV))
         tov_ff <= 1'b0;
   end

   assign external_interrupt_zero_clr = (wr_if & wdata_ff[IF_EXTERNAL_INTERRUPT_ZERO])
      | (vector_fire & (src_ff == SRC_EXTERNAL_INTERRUPT_ZERO));
   assign external_interrupt_one_clr = (wr_if & wdata_ff[IF_EXTERNAL_INTERRUPT_ONE])
      | (vector_fire & (src_ff == SRC_EXTERNAL_INTERRUPT_ONE));

   mirs_extint u_external_interrupt_zero (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_external_interrupt_zero_pin),
      .sense(mirs_sense_t'(ic_ff[IC_SENSE0_LSB+:2])),
      .flag_clear(external_interrupt_zero_clr),
      .flag(external_interrupt_zero_flag),
      .request(external_interrupt_zero_req)
   );

   mirs_extint u_external_interrupt_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_external_interrupt_one_pin),
      .sense(mirs_sense_t'(ic_ff[IC_SENSE1_LSB+:2])),
      .flag_clear(external_interrupt_one_clr),
      .flag(external_interrupt_one_flag),
      .request(external_interrupt_one_req)
   );

   assign low_level = |(~portb_pins & ~portb_special);
   assign req[SRC_EXTERNAL_INTERRUPT_ZERO] = external_interrupt_zero_req & ic_ff[IC_EXTERNAL_INTERRUPT_ZERO_EN];
   assign req[SRC_EXTERNAL_INTERRUPT_ONE] = external_interrupt_one_req & ic_ff[IC_EXTERNAL_INTERRUPT_ONE_EN];
   assign req[SRC_LOWLVL] = low_level & ic_ff[IC_LOWLVL_EN];
   assign req[SRC_TOV] = tov_ff & ic_ff[IC_TOV_EN];
   assign req[SRC_COMP] = comparator_interrupt;

   mirs_prio u_prio (
      .req(req),
      .any(req_any),
      .src(req_src)
   );

   // taken only at an instruction end or from sleep
   assign accept = (state_ff == SEQ_IDLE) & gie_ff & req_any & ~cpu_return_from_interrupt
      & (cpu_boundary | cpu_asleep);
   assign vector_fire = (state_ff == SEQ_RESP) & (cnt_ff == 4'h0);
   assign return_from_interrupt_done = (state_ff == SEQ_RETURN_FROM_INTERRUPT) & (cnt_ff == 4'h0);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         SEQ_IDLE:
         begin
            if (cpu_return_from_interrupt)
               nxt_state = SEQ_RETURN_FROM_INTERRUPT;
            else if (accept)
               nxt_state = SEQ_RESP;
         end
         SEQ_RESP:
         begin
            if (vector_fire)
               nxt_state = SEQ_IDLE;
         end
         SEQ_RETURN_FROM_INTERRUPT:
         begin
            if (return_from_interrupt_done)
               nxt_state = SEQ_HOLD;
         end
         SEQ_HOLD:
         begin
            if (cpu_boundary)
               nxt_state = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff <= SEQ_IDLE;
         cnt_ff <= 4'h0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (state_ff == SEQ_IDLE && cpu_return_from_interrupt)
            cnt_ff <= LOAD_RETURN_FROM_INTERRUPT;
         else if (accept)
            cnt_ff <= cpu_asleep ? LOAD_RESP_SLEEP : LOAD_RESP;
         else if (cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_ff <= SRC_EXTERNAL_INTERRUPT_ZERO;
         vector_ff <= VEC_RESET;
      end
      else if (accept)
      begin
         src_ff <= req_src;
         vector_ff <= VEC_RESET + 10'({7'h00, req_src} + 10'h001);
      end
   end

   // global enable; status contents are left to software
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         gie_ff <= 1'b0;
      else if (accept)
         gie_ff <= 1'b0;
      else if (return_from_interrupt_done)
         gie_ff <= 1'b1;
      else if (wr_st)
         gie_ff <= wdata_ff[ST_GIE];
   end

   assign irq_push_pc = (state_ff == SEQ_RESP);
   assign irq_pop_pc = (state_ff == SEQ_RETURN_FROM_INTERRUPT);
   assign irq_vector_valid = vector_fire;
   assign irq_vector = vector_ff;
   assign irq_wake = accept & cpu_asleep;

   chk_pullup_map: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 portb_pullup_en == $past({8{pullup_bit_ff}} & ~portb_special))
      else $error("pull-up map wrong");
   chk_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr[7:2] == ADDR_CTRL_STATUS[7:2]
      |=> rdata_ff[6] == 1'b0 && rdata_ff[2] == 1'b0)
      else $error("reserved bit read as one");
   chk_por_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> por_flag_ff) else $error("power-on flag not set");
   chk_wdt_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      wdt_reset_event |=> wdt_flag_ff) else $error("watchdog flag lost");
   chk_gie_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      state_ff == SEQ_RESP && $past(state_ff) == SEQ_IDLE |-> $past(gie_ff))
      else $error("taken with global enable off");
   chk_gie_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      accept |=> !gie_ff && irq_push_pc) else $error("enable not cleared");
   chk_resp_len: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && !cpu_asleep |=> !irq_vector_valid [*3] ##1 irq_vector_valid)
      else $error("response not four cycles");
   chk_sleep_len: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && cpu_asleep |-> ##8 irq_vector_valid)
      else $error("sleep response not eight cycles");
   chk_return_from_interrupt_len: assert property (@(posedge aclk) disable iff (!aresetn)
      state_ff == SEQ_IDLE && cpu_return_from_interrupt |=> irq_pop_pc [*4] ##1 gie_ff)
      else $error("return not four cycles");
   chk_hold_block: assert property (@(posedge aclk) disable iff (!aresetn)
      return_from_interrupt_done |=> !irq_push_pc [*2])
      else $error("no instruction after return");
   chk_prio_external_interrupt_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      accept && req[SRC_EXTERNAL_INTERRUPT_ZERO] |=> src_ff == SRC_EXTERNAL_INTERRUPT_ZERO && irq_vector == 10'h001)
      else $error("priority order wrong");
   chk_tov_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      vector_fire && src_ff == SRC_TOV && !timer_zero_overflow |=> !tov_ff)
      else $error("flag not cleared at vector");
endmodule
`default_nettype wire

// file: mirs_pkg.sv
// Purpose: shared constants and types of the interrupt and reset status block
// Assumes: 8-bit register data in the low lane of a 32-bit AXI4-Lite word
// Notes: byte address of a register is four times its index
package mirs_pkg;
   localparam logic [7:0] IDX_INT_CONTROL = 8'h06;
   localparam logic [7:0] IDX_CTRL_STATUS = 8'h07;
   localparam logic [7:0] IDX_INT_FLAG = 8'h08;
   localparam logic [7:0] IDX_STATUS = 8'h09;
   localparam logic [7:0] ADDR_INT_CONTROL = {IDX_INT_CONTROL[5:0], 2'b00};
   localparam logic [7:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS[5:0], 2'b00};
   localparam logic [7:0] ADDR_INT_FLAG = {IDX_INT_FLAG[5:0], 2'b00};
   localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};
   localparam int CS_PULLUP = 7;
   localparam int CS_SLEEP_EN = 5;
   localparam int CS_SLEEP_MODE = 4;
   localparam int CS_WDT_FLAG = 3;
   localparam int CS_PIN_FLAG = 1;
   localparam int CS_POR_FLAG = 0;
   localparam int IC_EXTERNAL_INTERRUPT_ONE_EN = 7;
   localparam int IC_EXTERNAL_INTERRUPT_ZERO_EN = 6;
   localparam int IC_LOWLVL_EN = 5;
   localparam int IC_TOV_EN = 4;
   localparam int IC_SENSE1_LSB = 2;
   localparam int IC_SENSE0_LSB = 0;
   localparam int IF_EXTERNAL_INTERRUPT_ONE = 7;
   localparam int IF_EXTERNAL_INTERRUPT_ZERO = 6;
   localparam int IF_TOV = 4;
   localparam int ST_GIE = 7;
   localparam logic [7:0] IC_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [3:0] RESP_CYCLES = 4'h4;
   localparam logic [3:0] SLEEP_EXTRA_CYCLES = 4'h4;
   localparam logic [3:0] RETURN_FROM_INTERRUPT_CYCLES = 4'h4;
   localparam logic [3:0] LOAD_RESP = RESP_CYCLES - 4'h1;
   localparam logic [3:0] LOAD_RESP_SLEEP = LOAD_RESP + SLEEP_EXTRA_CYCLES;
   localparam logic [3:0] LOAD_RETURN_FROM_INTERRUPT = RETURN_FROM_INTERRUPT_CYCLES - 4'h1;
   localparam int NUM_SRC = 5;
   localparam logic [2:0] SRC_EXTERNAL_INTERRUPT_ZERO = 3'h0;
   localparam logic [2:0] SRC_EXTERNAL_INTERRUPT_ONE = 3'h1;
   localparam logic [2:0] SRC_LOWLVL = 3'h2;
   localparam logic [2:0] SRC_TOV = 3'h3;
   localparam logic [2:0] SRC_COMP = 3'h4;
   localparam logic [9:0] VEC_RESET = 10'h000;
   typedef enum logic [1:0] {SENSE_LOW = 2'b00, SENSE_ANY = 2'b01,
      SENSE_FALL = 2'b10, SENSE_RISE = 2'b11} mirs_sense_t;
   typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_RESP = 2'b01,
      SEQ_RETURN_FROM_INTERRUPT = 2'b10, SEQ_HOLD = 2'b11} mirs_seq_t;
endpackage

// file: mirs_extint.sv
// Purpose: one external interrupt pin with sense control and edge flag
// Assumes: pin is synchronous to aclk
// Notes: level mode has no flag; request follows the sampled pin
`timescale 1ns/1ns
`default_nettype none
module mirs_extint
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire mirs_pkg::mirs_sense_t sense,
   input wire logic flag_clear,
   output logic flag,
   output logic request
);
   import mirs_pkg::*;
   logic pin_smp_ff;
   logic pin_prev_ff;
   logic flag_ff;
   logic edge_hit;

   // pin read whatever its direction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_smp_ff <= 1'b1;
         pin_prev_ff <= 1'b1;
      end
      else
      begin
         pin_smp_ff <= pin;
         pin_prev_ff <= pin_smp_ff;
      end
   end

   always_comb
   begin
      unique case (sense)
         SENSE_LOW: edge_hit = 1'b0;
         SENSE_ANY: edge_hit = pin_smp_ff ^ pin_prev_ff;
         SENSE_FALL: edge_hit = pin_prev_ff & ~pin_smp_ff;
         SENSE_RISE: edge_hit = ~pin_prev_ff & pin_smp_ff;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flag_ff <= 1'b0;
      else if (sense == SENSE_LOW)
         flag_ff <= 1'b0;
      else if (edge_hit)
         flag_ff <= 1'b1;
      else if (flag_clear)
         flag_ff <= 1'b0;
   end

   assign flag = flag_ff;
   assign request = (sense == SENSE_LOW) ? ~pin_smp_ff : flag_ff;

   chk_level_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      sense == SENSE_LOW |=> !flag_ff) else $error("level mode left a flag");
   chk_level_request: assert property (@(posedge aclk) disable iff (!aresetn)
      (sense == SENSE_LOW && !pin) ##1 (sense == SENSE_LOW) |-> request)
      else $error("low level not requesting");
   chk_fall_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      ($fell(pin) && sense == SENSE_FALL) ##1 (sense == SENSE_FALL) |=> flag_ff)
      else $error("falling edge lost");
endmodule
`default_nettype wire

// file: mirs_prio.sv
// Purpose: fixed priority pick among pending enabled sources
// Assumes: bit 0 is the highest priority source
// Notes: lowest index wins
`timescale 1ns/1ns
`default_nettype none
module mirs_prio
(
   input wire logic [mirs_pkg::NUM_SRC-1:0] req,
   output logic any,
   output logic [2:0] src
);
   import mirs_pkg::*;
   always_comb
   begin
      any = |req;
      src = SRC_EXTERNAL_INTERRUPT_ZERO;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i])
            src = 3'(i);
      end
   end
endmodule
`default_nettype wire

// file: mirs_cpu_model.sv
// Purpose: cpu side model giving boundaries and returns
// Assumes: two-cycle instructions outside interrupt work
// Notes: return pulse follows the bench request by one cycle
`timescale 1ns/1ns
`default_nettype none
module mirs_cpu_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic return_from_interrupt_req,
   input wire logic irq_push_pc,
   input wire logic irq_pop_pc,
   output logic cpu_boundary,
   output logic cpu_return_from_interrupt
);
   logic phase_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase_ff <= 1'b0;
         cpu_boundary <= 1'b0;
         cpu_return_from_interrupt <= 1'b0;
      end
      else
      begin
         phase_ff <= !phase_ff;
         // instruction ends only on its second cycle
         cpu_boundary <= phase_ff && !irq_push_pc && !irq_pop_pc;
         cpu_return_from_interrupt <= return_from_interrupt_req;
      end
   end
endmodule
`default_nettype wire

// file: tb_mirs_top.sv
// Purpose: self-checking bench of the interrupt and status block
// Assumes: axi master driven at rising edges
// Notes: vector and push counts checked per interrupt
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_mirs_top;
   import mirs_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, return_from_interrupt_req = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h1;
   logic ext_external_interrupt_zero_pin = 1'b1, ext_external_interrupt_one_pin = 1'b1;
   logic [7:0] portb_pins = 8'hff, portb_special = 8'h00;
   logic timer_zero_overflow = 1'b0, comparator_interrupt = 1'b0;
   logic wdt_reset_event = 1'b0, pin_reset_event = 1'b0;
   logic cpu_asleep = 1'b0, cpu_sleep_instr = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, cpu_boundary, cpu_return_from_interrupt;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] portb_pullup_en;
   logic sleep_enter, sleep_mode_select, irq_push_pc, irq_pop_pc;
   logic irq_vector_valid, irq_wake;
   logic [9:0] irq_vector;
   int fails = 0, checked = 0, cyc = 0, pushes = 0, pops = 0, wakes = 0;
   mirs_top mirs_top_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .ext_external_interrupt_zero_pin,
      .ext_external_interrupt_one_pin, .portb_pins, .portb_special, .timer_zero_overflow,
      .comparator_interrupt, .wdt_reset_event, .pin_reset_event,
      .cpu_boundary, .cpu_asleep, .cpu_return_from_interrupt, .cpu_sleep_instr,
      .portb_pullup_en, .sleep_enter, .sleep_mode_select, .irq_push_pc,
      .irq_pop_pc, .irq_vector_valid, .irq_vector, .irq_wake);
   mirs_cpu_model mirs_cpu_model_i (.aclk, .aresetn, .return_from_interrupt_req,
      .irq_push_pc, .irq_pop_pc, .cpu_boundary, .cpu_return_from_interrupt);
   always #10 aclk = !aclk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (irq_push_pc === 1'b1)
         pushes <= pushes + 1;
      if (irq_pop_pc === 1'b1)
         pops <= pops + 1;
      if (irq_wake === 1'b1)
         wakes <= wakes + 1;
      if (cyc == 5000)
      begin
         fails++;
         test_done;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      r = (a inside {ADDR_INT_CONTROL, ADDR_CTRL_STATUS, ADDR_INT_FLAG,
         ADDR_STATUS}) ? RESP_OKAY : RESP_SLVERR;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, r)
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      `CHK(rdata, e)
      `CHK(rresp, r)
   endtask
   task automatic pulse_tov;
      timer_zero_overflow <= 1'b1;
      @(posedge aclk);
      timer_zero_overflow <= 1'b0;
   endtask
   // start by global enable write or by a return, then await the vector
   task automatic irq_go(input logic how, input logic [9:0] v, input int n);
      int p0;
      int q0;
      p0 = pushes;
      q0 = pops;
      if (how)
      begin
         @(posedge aclk);
         return_from_interrupt_req <= 1'b1;
         @(posedge aclk);
         return_from_interrupt_req <= 1'b0;
      end
      else
         wr(ADDR_STATUS, 8'h80);
      while (irq_vector_valid !== 1'b1)
         @(posedge aclk);
      `CHK(irq_vector, v)
      @(posedge aclk);
      `CHK(pushes - p0, n)
      `CHK(pops - q0, how ? 4 : 0)
   endtask
   task automatic t_reg;
      rd(ADDR_CTRL_STATUS, 32'h01, RESP_OKAY);
      wr(ADDR_CTRL_STATUS, 8'hff);
      rd(ADDR_CTRL_STATUS, 32'hb1, RESP_OKAY);
      `CHK(portb_pullup_en, 8'hff)
      `CHK(sleep_mode_select, 1'b1)
      portb_special <= 8'h03;
      repeat (3) @(posedge aclk);
      `CHK(portb_pullup_en, 8'hfc)
      cpu_sleep_instr <= 1'b1;
      @(posedge aclk);
      cpu_sleep_instr <= 1'b0;
      `CHK(sleep_enter, 1'b1)
      $display("t_reg done");
   endtask
   task automatic t_flags;
      wdt_reset_event <= 1'b1;
      pin_reset_event <= 1'b1;
      @(posedge aclk);
      wdt_reset_event <= 1'b0;
      pin_reset_event <= 1'b0;
      rd(ADDR_CTRL_STATUS, 32'hbb, RESP_OKAY);
      wr(ADDR_CTRL_STATUS, 8'h00);
      rd(ADDR_CTRL_STATUS, 32'h00, RESP_OKAY);
      `CHK(portb_pullup_en, 8'h00)
      `CHK(sleep_mode_select, 1'b0)
      cpu_sleep_instr <= 1'b1;
      @(posedge aclk);
      cpu_sleep_instr <= 1'b0;
      `CHK(sleep_enter, 1'b0)
      wr(8'h00, 8'hff);
      rd(8'h00, 32'h0, RESP_SLVERR);
      $display("t_flags done");
   endtask
   task automatic t_irq;
      wr(ADDR_INT_CONTROL, 8'h52);
      ext_external_interrupt_zero_pin <= 1'b0;
      pulse_tov;
      repeat (4) @(posedge aclk);
      `CHK(irq_push_pc, 1'b0)
      rd(ADDR_INT_FLAG, 32'h50, RESP_OKAY);
      irq_go(1'b0, 10'h001, 4);
      rd(ADDR_STATUS, 32'h00, RESP_OKAY);
      rd(ADDR_INT_FLAG, 32'h10, RESP_OKAY);
      irq_go(1'b1, 10'h004, 4);
      cpu_asleep <= 1'b1;
      pulse_tov;
      irq_go(1'b0, 10'h004, 8);
      cpu_asleep <= 1'b0;
      `CHK(wakes, 1)
      $display("t_irq done");
   endtask
   task automatic t_lvl;
      wr(ADDR_INT_CONTROL, 8'ha0);
      portb_pins <= 8'hfe;
      ext_external_interrupt_one_pin <= 1'b0;
      comparator_interrupt <= 1'b1;
      rd(ADDR_INT_FLAG, 32'h00, RESP_OKAY);
      irq_go(1'b0, 10'h002, 4);
      ext_external_interrupt_one_pin <= 1'b1;
      portb_pins <= 8'hfb;
      irq_go(1'b1, 10'h003, 4);
      portb_pins <= 8'hff;
      irq_go(1'b1, 10'h005, 4);
      comparator_interrupt <= 1'b0;
      wr(ADDR_INT_CONTROL, 8'h43);
      ext_external_interrupt_zero_pin <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(ADDR_INT_FLAG, 32'h40, RESP_OKAY);
      wr(ADDR_INT_FLAG, 8'h40);
      rd(ADDR_INT_FLAG, 32'h00, RESP_OKAY);
      wr(ADDR_INT_CONTROL, 8'h41);
      ext_external_interrupt_zero_pin <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(ADDR_INT_FLAG, 32'h40, RESP_OKAY);
      $display("t_lvl done");
   endtask
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reg;
      t_flags;
      t_irq;
      t_lvl;
      test_done;
   end
endmodule
`default_nettype wire
